// ### hw/pife_pkg.sv
// Package with register map, field positions, reset values and modes of the peripheral flag and enable block.
package pife_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFF_FLAGS_1 = 8'h00;
    localparam logic [7:0] OFF_FLAGS_2 = 8'h04;
    localparam logic [7:0] OFF_ENABLES_1 = 8'h08;
    localparam logic [7:0] OFF_ENABLES_2 = 8'h0c;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_PENDING = 8'h14;

    // Reset values of the flag, enable and control registers.
    localparam logic [7:0] RST_FLAGS_1 = 8'h00;
    localparam logic [4:0] RST_FLAGS_2 = 5'h00;
    localparam logic [7:0] RST_ENABLES_1 = 8'h00;
    localparam logic [4:0] RST_ENABLES_2 = 5'h00;
    localparam logic [2:0] RST_CONTROL = 3'h0;

    // First flag and enable register bit positions.
    localparam int B1_PARALLEL = 7;
    localparam int B1_CONVERTER = 6;
    localparam int B1_RECEIVE = 5;
    localparam int B1_TRANSMIT = 4;
    localparam int B1_SYNC_SERIAL = 3;
    localparam int B1_CAPCOMP_ONE = 2;
    localparam int B1_TIMER_TWO = 1;
    localparam int B1_TIMER_ONE = 0;

    // Second flag and enable register bit positions.
    localparam int B2_MEM_WRITE = 4;
    localparam int B2_BUS_COLL = 3;
    localparam int B2_LOW_VOLT = 2;
    localparam int B2_TIMER_THREE = 1;
    localparam int B2_CAPCOMP_TWO = 0;
    localparam int W2 = 5;

    // Control register bit positions.
    localparam int C_GLOBAL = 0;
    localparam int C_GROUP = 1;
    localparam int C_PRIORITY = 2;

    // Capture/compare unit operating modes.
    typedef enum logic [1:0] {
        PIFE_CC_CAPTURE = 2'h0,
        PIFE_CC_COMPARE = 2'h1,
        PIFE_CC_PWM = 2'h3
    } pife_cc_mode_t;

endpackage : pife_pkg

// ### hw/pife_flag_if.sv
// Interface between the register logic and one bank of sticky event flags.
`timescale 1ns/1ps
interface pife_flag_if #(
    parameter int N = 5
);
    logic [N-1:0] event_set; // One-cycle event pulses, one per flag.
    logic wr_en; // Software write strobe for the bank.
    logic [N-1:0] wr_data; // Value written by software.
    logic [N-1:0] flags; // Current flag state.

    modport bank (input event_set, input wr_en, input wr_data, output flags);
    modport ctrl (output event_set, output wr_en, output wr_data, input flags);
endinterface : pife_flag_if

// ### hw/pife_flag_bank.sv
// Bank of sticky event flags that hardware sets and software writes.
`timescale 1ns/1ps
module pife_flag_bank #(
    parameter int N = 5,
    parameter logic [N-1:0] RST = '0
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Flag bank connection.
    pife_flag_if.bank fi
);

    logic [N-1:0] flags_q; // Sticky flag state.
    logic [N-1:0] flags_d; // Next flag state.

    // An event in the same cycle as a software write of zero wins, so no event is lost.
    always_comb begin
        flags_d = fi.wr_en ? fi.wr_data : flags_q;
        flags_d = flags_d | fi.event_set;
    end

    // Flags hold until software writes them to zero.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flags_q <= RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign fi.flags = flags_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_event_sets_flag: assert property (|fi.event_set |=>
        ((flags_q & $past(fi.event_set)) == $past(fi.event_set)))
        else $error("Flag event did not set its flag");
    a_flag_holds: assert property (!fi.wr_en && !(|fi.event_set) |=> flags_q == $past(flags_q))
        else $error("Flag changed without a write or event");

endmodule : pife_flag_bank

// ### hw/pife_top.sv
// Peripheral interrupt flag and enable registers with APB access and gating toward the core.
//
// Contract
// - Flags set on events regardless of enables.
// - First flag register: eight bits, zero reset.
// - Receive flag bit 5 read-only, follows buffer.
// - Transmit flag bit 4 read-only, follows buffer.
// - Parallel port flag sets on access completion.
// - Converter flag sets when conversion finishes.
// - Sync serial flag sets on transfer completion.
// - Timer two match and timer one overflow.
// - Timer one flag held until software clear.
// - Second register bit 4: memory write done.
// - Second register bit 3: bus collision.
// - Second register bit 2: low voltage.
// - Second register bit 1: timer three overflow.
// - Second register bit 0: capcomp two.
// - First enable register, eight bits, zero reset.
// - Second registers: bits 7-5 read zero.
// - No priority: group enable gates peripherals.
// - Priority bits ignored unless priority enabled.
// - With priority, group enable gates low level.
`timescale 1ns/1ps
module pife_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Peripheral events, one-cycle pulses unless noted.
    input wire logic parallel_access_done,
    input wire logic converter_done,
    input wire logic receive_buffer_full,
    input wire logic transmit_buffer_empty,
    input wire logic sync_serial_done,
    input wire logic capcomp_one_capture,
    input wire logic capcomp_one_match,
    input wire logic [1:0] capcomp_one_mode,
    input wire logic timer_two_period_match,
    input wire logic timer_one_overflow,
    input wire logic memory_write_done,
    input wire logic bus_collision,
    input wire logic low_voltage_trip,
    input wire logic timer_three_overflow,
    input wire logic capcomp_two_capture,
    input wire logic capcomp_two_match,
    input wire logic [1:0] capcomp_two_mode,
    // Per-source priority bits from the priority registers, high level when one.
    input wire logic [7:0] priority_bits_1,
    input wire logic [4:0] priority_bits_2,
    // Requests toward the core.
    output logic [12:0] pending,
    output logic irq_high,
    output logic irq_low
);

    // Only the low address bits are decoded; the map needs five of them.
    if (ADDR_W < 5) begin : g_bad_addr
        $error("ADDR_W must be at least 5");
    end

    // Bus phase decode.
    logic setup_phase; // First cycle of a transfer.
    logic wr_access; // Write commits at this edge.
    logic [7:0] addr8; // Address widened or cut to the map width.
    logic [7:0] wbyte; // Lowest write byte lane, the only live one.
    logic wbyte_en; // Byte lane 0 strobe.

    // Register state.
    logic [7:0] enables_1_q; // First enable register.
    logic [4:0] enables_2_q; // Second enable register.
    logic [2:0] control_q; // Global, group and priority enables.
    logic receive_q; // Registered receive-full level.
    logic transmit_q; // Registered transmit-empty level.
    logic pready_q; // Access-phase ready.
    logic [31:0] prdata_q; // Read data held for the access phase.
    logic pslverr_q; // Unmapped address answer.
    logic [12:0] pending_q; // Per-source pending requests.
    logic irq_high_q; // High-level request to the core.
    logic irq_low_q; // Low-level request to the core.

    // Assembled register views.
    logic [7:0] flags_1; // First flag register as read.
    logic [4:0] flags_2; // Second flag register as read.
    logic [12:0] pend_d; // Flag AND enable per source.
    logic [12:0] prio; // Priority bits of all sources.
    logic cc1_event; // Capcomp one event for its mode.
    logic cc2_event; // Capcomp two event for its mode.
    logic hit; // Address maps to a register.
    logic [31:0] rdata_d; // Read mux output.

    // Flag banks: six sticky bits of the first register and all five of the second.
    pife_flag_if #(.N(6)) fb1 ();
    pife_flag_if #(.N(5)) fb2 ();

    // The read-only receive and transmit bits live outside bank 1, so its reset value skips them.
    pife_flag_bank #(
        .N(6),
        .RST({pife_pkg::RST_FLAGS_1[pife_pkg::B1_PARALLEL:pife_pkg::B1_CONVERTER],
            pife_pkg::RST_FLAGS_1[pife_pkg::B1_SYNC_SERIAL:pife_pkg::B1_TIMER_ONE]})
    ) u_bank_1 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .fi(fb1.bank)
    );

    pife_flag_bank #(.N(5), .RST(pife_pkg::RST_FLAGS_2)) u_bank_2 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .fi(fb2.bank)
    );

    assign addr8 = 8'(paddr);
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite && pready_q;
    assign wbyte = pwdata[7:0];
    assign wbyte_en = pstrb[0];

    // Capture/compare events count only in the mode that uses them; PWM never flags.
    assign cc1_event = (capcomp_one_mode == pife_pkg::PIFE_CC_CAPTURE && capcomp_one_capture)
        || (capcomp_one_mode == pife_pkg::PIFE_CC_COMPARE && capcomp_one_match);
    assign cc2_event = (capcomp_two_mode == pife_pkg::PIFE_CC_CAPTURE && capcomp_two_capture)
        || (capcomp_two_mode == pife_pkg::PIFE_CC_COMPARE && capcomp_two_match);

    // Bank 1 order: parallel, converter, sync serial, capcomp one, timer two, timer one.
    assign fb1.event_set = {parallel_access_done, converter_done, sync_serial_done,
        cc1_event, timer_two_period_match, timer_one_overflow};
    assign fb1.wr_en = wr_access && wbyte_en && addr8 == pife_pkg::OFF_FLAGS_1;
    // The receive and transmit bits are read-only, so their write data is skipped.
    assign fb1.wr_data = {wbyte[pife_pkg::B1_PARALLEL], wbyte[pife_pkg::B1_CONVERTER],
        wbyte[pife_pkg::B1_SYNC_SERIAL:pife_pkg::B1_TIMER_ONE]};

    // Bank 2 follows the register's own bit order.
    assign fb2.event_set = {memory_write_done, bus_collision, low_voltage_trip,
        timer_three_overflow, cc2_event};
    assign fb2.wr_en = wr_access && wbyte_en && addr8 == pife_pkg::OFF_FLAGS_2;
    assign fb2.wr_data = wbyte[pife_pkg::W2-1:0];

    // Read views; upper bits of the second register read as zero.
    assign flags_1 = {fb1.flags[5], fb1.flags[4], receive_q, transmit_q, fb1.flags[3:0]};
    assign flags_2 = fb2.flags;

    // Receive and transmit flags mirror the serial buffer state; the buffer access clears them.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            receive_q <= pife_pkg::RST_FLAGS_1[pife_pkg::B1_RECEIVE];
            transmit_q <= pife_pkg::RST_FLAGS_1[pife_pkg::B1_TRANSMIT];
        end else begin
            receive_q <= receive_buffer_full;
            transmit_q <= transmit_buffer_empty;
        end
    end

    // Enable registers and control bits take byte lane 0 at the committing edge.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            enables_1_q <= pife_pkg::RST_ENABLES_1;
            enables_2_q <= pife_pkg::RST_ENABLES_2;
            control_q <= pife_pkg::RST_CONTROL;
        end else if (wr_access && wbyte_en) begin
            // All eight enables take the byte as written.
            if (addr8 == pife_pkg::OFF_ENABLES_1) begin
                enables_1_q <= wbyte;
            end
            // Upper bits of the byte are dropped, so they can never read back as one.
            if (addr8 == pife_pkg::OFF_ENABLES_2) begin
                enables_2_q <= wbyte[pife_pkg::W2-1:0];
            end
            // Software owns the global, group and priority-level enables.
            if (addr8 == pife_pkg::OFF_CONTROL) begin
                control_q <= wbyte[2:0];
            end
        end
    end

    // Address decode and read mux; unmapped reads return zero with an error.
    always_comb begin
        hit = 1'b1;
        rdata_d = 32'h0000_0000;
        unique case (addr8)
            // Sticky bits merged with the two buffer-level bits.
            pife_pkg::OFF_FLAGS_1: begin
                rdata_d[7:0] = flags_1;
            end
            // Five live bits; the rest of the word reads zero.
            pife_pkg::OFF_FLAGS_2: begin
                rdata_d[4:0] = flags_2;
            end
            // All eight enables are plain read/write bits.
            pife_pkg::OFF_ENABLES_1: begin
                rdata_d[7:0] = enables_1_q;
            end
            // Only the five implemented enables are stored.
            pife_pkg::OFF_ENABLES_2: begin
                rdata_d[4:0] = enables_2_q;
            end
            // Global, group and priority-level enables.
            pife_pkg::OFF_CONTROL: begin
                rdata_d[2:0] = control_q;
            end
            // Read-only view of the registered pending word.
            pife_pkg::OFF_PENDING: begin
                rdata_d[12:0] = pending_q;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // One wait-free access phase: ready rises the cycle after setup, for exactly one cycle.
    // Read data is captured at setup so the output comes straight from a flip-flop.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            // Ready follows every setup cycle by exactly one edge, so no wait state is ever inserted.
            pready_q <= setup_phase;
            // A write reads back zero; the register view is only returned for reads.
            if (setup_phase) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
                pslverr_q <= !hit;
            end else if (pready_q) begin
                // The error answer stands only as long as ready does.
                pslverr_q <= 1'b0;
            end
        end
    end

    // Per-source pending, flags ANDed with enables in the same source order.
    assign pend_d = {flags_1 & enables_1_q, flags_2 & enables_2_q};
    assign prio = {priority_bits_1, priority_bits_2};

    // Gating toward the core. Without priority levels every source is one level and the
    // group enable gates it; with levels, the group enable becomes the low-level enable.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pending_q <= 13'h0000;
            irq_high_q <= 1'b0;
            irq_low_q <= 1'b0;
        end else begin
            pending_q <= pend_d;
            // Priority bits are not looked at in this branch, so they cannot steer a request.
            if (!control_q[pife_pkg::C_PRIORITY]) begin
                irq_high_q <= control_q[pife_pkg::C_GLOBAL] && control_q[pife_pkg::C_GROUP]
                    && (|pend_d);
                irq_low_q <= 1'b0;
            end else begin
                // High-priority sources bypass the group enable; only the global enable gates them.
                irq_high_q <= control_q[pife_pkg::C_GLOBAL] && (|(pend_d & prio));
                irq_low_q <= control_q[pife_pkg::C_GLOBAL] && control_q[pife_pkg::C_GROUP]
                    && (|(pend_d & ~prio));
            end
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pending = pending_q;
    assign irq_high = irq_high_q;
    assign irq_low = irq_low_q;

    // Every property is sampled on the core clock and is off while reset is low.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // The receive bit is a registered copy of the buffer level.
    a_receive_follows: assert property (receive_buffer_full |=> flags_1[pife_pkg::B1_RECEIVE])
        else $error("Receive flag did not follow the buffer");

    // The transmit bit drops the cycle after the buffer fills.
    a_transmit_follows: assert property (!transmit_buffer_empty |=> !flags_1[pife_pkg::B1_TRANSMIT])
        else $error("Transmit flag stayed set after the buffer filled");

    // In PWM mode the unit's events must never reach the flag.
    a_pwm_no_flag: assert property (capcomp_one_mode == pife_pkg::PIFE_CC_PWM && !fb1.wr_en
        && !flags_1[pife_pkg::B1_CAPCOMP_ONE] |=> !flags_1[pife_pkg::B1_CAPCOMP_ONE])
        else $error("Capcomp one flag set in PWM mode");

    // A qualifying event of unit two is never lost, even against a clear.
    a_cc2_sets: assert property (cc2_event |=> flags_2[pife_pkg::B2_CAPCOMP_TWO])
        else $error("Capcomp two event lost");

    // A first enable write lands at the committing edge.
    a_enable_write: assert property (wr_access && wbyte_en && addr8 == pife_pkg::OFF_ENABLES_1
        |=> enables_1_q == $past(wbyte))
        else $error("First enable register write lost");

    // Unimplemented upper bits of the second registers read as zero.
    a_upper_zero: assert property (pready_q && !$past(pwrite) && ($past(addr8) == pife_pkg::OFF_FLAGS_2
        || $past(addr8) == pife_pkg::OFF_ENABLES_2) |-> prdata_q[7:5] == 3'h0)
        else $error("Unimplemented bits read nonzero");

    // Without priority levels the group enable gates both requests.
    a_group_gates: assert property (!control_q[pife_pkg::C_PRIORITY] && !control_q[pife_pkg::C_GROUP]
        |=> !irq_high_q && !irq_low_q)
        else $error("Peripheral request passed with group enable clear");

    // The low-level request exists only with priority levels on.
    a_prio_ignored: assert property (!control_q[pife_pkg::C_PRIORITY] |=> !irq_low_q)
        else $error("Low level used while priority disabled");

    // With priority levels the group enable gates the low level.
    a_low_gated: assert property (control_q[pife_pkg::C_PRIORITY] && !control_q[pife_pkg::C_GROUP]
        |=> !irq_low_q)
        else $error("Low level request passed with group enable clear");

    // The pending word is flag AND enable, one cycle later.
    a_pending_and: assert property (##1 pending_q == $past(pend_d))
        else $error("Pending does not match flags and enables");

    // Ready is a single-cycle pulse after every setup cycle.
    a_ready_pulse: assert property (setup_phase |=> pready_q ##1 !pready_q || setup_phase)
        else $error("Ready did not pulse after setup");

    // A timer one flag holds until the write that clears it.
    a_timer_one_held: assert property (timer_one_overflow |=> flags_1[pife_pkg::B1_TIMER_ONE] [*2]
        or (flags_1[pife_pkg::B1_TIMER_ONE] ##1 $past(fb1.wr_en)))
        else $error("Timer one flag not held");

    // Main scenarios: each request level raised, an event against a clear, an unmapped access.
    c_high_irq: cover property (!irq_high_q ##1 irq_high_q);
    c_low_irq: cover property (control_q[pife_pkg::C_PRIORITY] ##1 irq_low_q);
    c_event_on_clear: cover property (fb1.wr_en && |fb1.event_set);
    c_unmapped: cover property (pslverr_q && pready_q);

endmodule : pife_top

// ### tb/pife_periph_model.sv
// Behavioural model of the on-chip peripherals that raise events toward the flag block.
`timescale 1ns/1ps
module pife_periph_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Bench requests: fire bit 12 is the parallel port, bit 0 capture/compare two.
    input wire logic [12:0] fire,
    input wire logic rx_level,
    input wire logic tx_level,
    input wire logic [1:0] cc1_mode,
    input wire logic [1:0] cc2_mode,
    // Event pulses, then rx, tx, capture and match of unit one, capture and match of unit two.
    output logic [12:0] ev_q,
    output logic [5:0] side_q
);
    // Every output changes just after an edge, so each event is a clean one-cycle pulse.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ev_q <= 13'h0000;
            side_q <= 6'h00;
        end else begin
            ev_q <= fire;
            // A timer in PWM mode still captures and matches; the block has to drop both.
            side_q <= {rx_level, tx_level,
                fire[7] && cc1_mode != pife_pkg::PIFE_CC_COMPARE, fire[7] && cc1_mode != pife_pkg::PIFE_CC_CAPTURE,
                fire[0] && cc2_mode != pife_pkg::PIFE_CC_COMPARE, fire[0] && cc2_mode != pife_pkg::PIFE_CC_CAPTURE};
        end
    end
endmodule : pife_periph_model

// ### tb/peripheral_irq_flag_enable_test.sv
// Self-checking bench of the peripheral flag and enable block.
`timescale 1ns/1ps
module peripheral_irq_flag_enable_test;
    // One ordinary case: event index, second bank or not, expected flag byte, capture/compare mode.
    typedef struct {int idx; logic bank; logic [7:0] exp; logic [1:0] mode;} pife_row_t;
    logic ref_clk = 1'b0; // Core clock.
    logic nrst = 1'b0; // Reset, low at start.
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h1;
    logic pready, pslverr, irq_high, irq_low;
    logic [31:0] prdata;
    logic [12:0] fire = 13'h0000, ev, pending; // Model requests, events, pending outputs.
    logic rx_level = 1'b0, tx_level = 1'b0;
    logic [1:0] cc1_mode = 2'h0, cc2_mode = 2'h0;
    logic [7:0] prio_1 = 8'h00; // Priority bits, ignored unless priority levels are on.
    logic [4:0] prio_2 = 5'h00;
    logic [5:0] side;
    int err_count = 0;
    int checks_done = 0;
    pife_row_t rows [11] = '{'{12, 0, 8'h80, 0}, '{11, 0, 8'h40, 0}, '{8, 0, 8'h08, 0}, '{7, 0, 8'h04, 1},
        '{6, 0, 8'h02, 0}, '{5, 0, 8'h01, 0}, '{4, 1, 8'h10, 0}, '{3, 1, 8'h08, 0}, '{2, 1, 8'h04, 0},
        '{1, 1, 8'h02, 0}, '{0, 1, 8'h01, 0}};

    // Free-running core clock, 40 ns period.
    always #20 ref_clk = ~ref_clk;

    pife_periph_model model_u (.ref_clk(ref_clk), .nrst(nrst), .fire(fire), .rx_level(rx_level),
        .tx_level(tx_level), .cc1_mode(cc1_mode), .cc2_mode(cc2_mode), .ev_q(ev), .side_q(side));

    pife_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .parallel_access_done(ev[12]), .converter_done(ev[11]), .receive_buffer_full(side[5]),
        .transmit_buffer_empty(side[4]), .sync_serial_done(ev[8]), .capcomp_one_capture(side[3]),
        .capcomp_one_match(side[2]), .capcomp_one_mode(cc1_mode), .timer_two_period_match(ev[6]),
        .timer_one_overflow(ev[5]), .memory_write_done(ev[4]), .bus_collision(ev[3]),
        .low_voltage_trip(ev[2]), .timer_three_overflow(ev[1]), .capcomp_two_capture(side[1]),
        .capcomp_two_match(side[0]), .capcomp_two_mode(cc2_mode), .priority_bits_1(prio_1),
        .priority_bits_2(prio_2), .pending(pending), .irq_high(irq_high), .irq_low(irq_low));

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // Compares with case equality, so an unknown never passes.
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk

    // One APB transfer, entered just after a rising edge; the request holds until pready is seen.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Just after each rising edge pready still shows what that edge sampled.
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (pready !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: no pready", $time);
            complete_run();
        end
        // Data and error are taken at the edge that saw pready, and only then is the request released.
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // An idle cycle keeps two drives of psel out of one time step.
        @(posedge ref_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    // Reads a register and expects no slave error.
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, 32'h0);
    endtask : rd

    // Fires one event; the flag is settled three edges after the pulse ends.
    task automatic pulse(input int i);
        fire <= 13'h0001 << i;
        @(posedge ref_clk);
        fire <= 13'h0000;
        repeat (3) @(posedge ref_clk);
    endtask : pulse

    // Writes the control register and checks both requests once they have settled.
    task automatic ctl(input logic [7:0] c, input logic hi, input logic lo);
        wr(pife_pkg::OFF_CONTROL, {24'h0, c});
        @(negedge ref_clk);
        chk({30'h0, irq_high, irq_low}, {30'h0, hi, lo});
        @(posedge ref_clk);
    endtask : ctl

    initial begin
        logic [31:0] r;
        logic e;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        chk({17'h0, pending, irq_high, irq_low}, 32'h0);
        for (int o = 0; o < 24; o += 4) rd(8'(o), 32'h0);
        $display("test reset finished");
        // Each sticky source sets only its own bit with all enables off, then clears on a write of zero.
        foreach (rows[i]) begin
            cc1_mode <= rows[i].mode;
            cc2_mode <= rows[i].mode;
            pulse(rows[i].idx);
            r = {24'h0, rows[i].exp};
            rd(rows[i].bank ? pife_pkg::OFF_FLAGS_2 : pife_pkg::OFF_FLAGS_1, r);
            chk({19'h0, pending}, 32'h0);
            wr(rows[i].bank ? pife_pkg::OFF_FLAGS_2 : pife_pkg::OFF_FLAGS_1, 32'h0);
            rd(rows[i].bank ? pife_pkg::OFF_FLAGS_2 : pife_pkg::OFF_FLAGS_1, 32'h0);
        end
        $display("test sources finished");
        cc1_mode <= pife_pkg::PIFE_CC_PWM;
        cc2_mode <= pife_pkg::PIFE_CC_PWM;
        pulse(7);
        pulse(0);
        rd(pife_pkg::OFF_FLAGS_1, 32'h0);
        rd(pife_pkg::OFF_FLAGS_2, 32'h0);
        rx_level <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wr(pife_pkg::OFF_FLAGS_1, 32'h0);
        rd(pife_pkg::OFF_FLAGS_1, 32'h20);
        rx_level <= 1'b0;
        tx_level <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wr(pife_pkg::OFF_FLAGS_1, 32'h0);
        rd(pife_pkg::OFF_FLAGS_1, 32'h10);
        tx_level <= 1'b0;
        repeat (3) @(posedge ref_clk);
        wr(pife_pkg::OFF_FLAGS_1, 32'hffff_ffff);
        rd(pife_pkg::OFF_FLAGS_1, 32'hcf);
        wr(pife_pkg::OFF_FLAGS_2, 32'hff);
        rd(pife_pkg::OFF_FLAGS_2, 32'h1f);
        wr(pife_pkg::OFF_ENABLES_1, 32'hff);
        rd(pife_pkg::OFF_ENABLES_1, 32'hff);
        wr(pife_pkg::OFF_ENABLES_2, 32'hff);
        rd(pife_pkg::OFF_ENABLES_2, 32'h1f);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test registers finished");
        // Flags are cleared with all thirteen enables still set from the register test.
        wr(pife_pkg::OFF_FLAGS_1, 32'h0);
        wr(pife_pkg::OFF_FLAGS_2, 32'h0);
        wr(pife_pkg::OFF_ENABLES_2, 32'h0);
        pstrb <= 4'h0;
        wr(pife_pkg::OFF_ENABLES_1, 32'h0);
        pstrb <= 4'h1;
        rd(pife_pkg::OFF_ENABLES_1, 32'hff);
        // The parallel port enable is kept at zero from here on.
        wr(pife_pkg::OFF_ENABLES_1, 32'h40);
        pulse(11);
        chk({19'h0, pending}, 32'h800);
        rd(pife_pkg::OFF_PENDING, 32'h800);
        chk({30'h0, irq_high, irq_low}, 32'h0);
        ctl(8'h01, 1'b0, 1'b0);
        ctl(8'h03, 1'b1, 1'b0);
        ctl(8'h05, 1'b0, 1'b0);
        ctl(8'h07, 1'b0, 1'b1);
        prio_1 <= 8'h40;
        ctl(8'h05, 1'b1, 1'b0);
        ctl(8'h03, 1'b1, 1'b0);
        $display("test gating finished");
        nrst <= 1'b0;
        @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        chk({17'h0, pending, irq_high, irq_low}, 32'h0);
        rd(pife_pkg::OFF_ENABLES_1, 32'h0);
        rd(pife_pkg::OFF_FLAGS_1, 32'h0);
        $display("test second reset finished");
        complete_run();
    end
endmodule : peripheral_irq_flag_enable_test
